// [rtl/ufsp_pkg.sv]
package ufsp_pkg;
  // register indices; byte address is four times the index
  localparam logic [9:0] IDX_ADDR_LOW = 10'h0a8;
  localparam logic [9:0] IDX_ADDR_HIGH = 10'h0a9;
  localparam logic [9:0] IDX_READ_RESULT = 10'h0aa;
  localparam logic [9:0] IDX_WRITE_SOURCE = 10'h0ab;
  localparam logic [9:0] IDX_WRITE_TIMING = 10'h0e1;
  localparam logic [9:0] IDX_CALL_KEY = 10'h0e2;
  localparam logic [9:0] IDX_BLOCK_COUNT = 10'h0f1;
  localparam logic [9:0] IDX_CALL = 10'h0c0;
  localparam logic [9:0] IDX_STATUS = 10'h0c1;
  // call register fields
  localparam int CALL_CODE_LSB = 0;
  localparam int CALL_ACC_LSB = 8;
  localparam int CALL_X_LSB = 16;
  // status bits
  localparam int ST_BUSY = 0;
  localparam int ST_ISP = 1;
  localparam int ST_REJECT = 2;
  localparam int ST_KEY_OK = 3;
  // constants of the service interface
  localparam logic [7:0] KEY_VALUE = 8'h98;
  localparam logic [7:0] MASS_CONFIRM = 8'h55;
  localparam logic [7:0] BLKW_MAX = 8'h10;
  localparam logic [7:0] EP_PAGE_ERASE = 8'h17;
  localparam logic [7:0] EP_MASS_ERASE = 8'h1a;
  localparam logic [7:0] EP_READ_BYTE = 8'h11;
  localparam logic [7:0] EP_WRITE_BYTE = 8'h14;
  localparam logic [7:0] EP_BLOCK_READ = 8'h26;
  localparam logic [7:0] EP_BLOCK_WRITE = 8'h23;
  localparam logic [7:0] EP_EXIT = 8'h62;
  localparam logic [7:0] EP_ISP_START = 8'h00;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // key lifetime in instruction cycles, one instruction cycle per clock
  localparam int KEY_WINDOW_INSTR = 6;
  localparam int INSTR_CLKS = 1;
  localparam int KEY_WINDOW_CYC = KEY_WINDOW_INSTR * INSTR_CLKS;
  typedef enum logic [2:0] {
    UFSP_FOP_NONE = 3'h0,
    UFSP_FOP_READ = 3'h1,
    UFSP_FOP_WRITE = 3'h2,
    UFSP_FOP_PAGE = 3'h3,
    UFSP_FOP_MASS = 3'h4
  } ufsp_fop_t;
endpackage : ufsp_pkg

// [rtl/ufsp_flash_if.sv]
`timescale 1ns/1ps
// one flash operation per cycle, read data one cycle after a read
interface ufsp_flash_if #(parameter int AW = 13);
  import ufsp_pkg::*;
  ufsp_fop_t op;
  logic [AW-1:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic busy;
  modport ctrl(output op, output addr, output wdata, input rdata, input busy);
  modport mem(input op, input addr, input wdata, output rdata, output busy);
endinterface : ufsp_flash_if

// [rtl/ufsp_flash.sv]
`timescale 1ns/1ps
module ufsp_flash import ufsp_pkg::*; #(
  parameter int DEPTH = 8192,
  parameter int PAGE_BYTES = 64,
  parameter int AW = 13
) (
  input wire logic clk_in,
  input wire logic reset_n_in,
  ufsp_flash_if.mem fl
);
  logic [7:0] mem [DEPTH];
  logic erasing;
  logic [AW-1:0] eptr;
  logic [AW-1:0] eend;

  // erase walks one byte per clock
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      erasing <= 1'b0;
      eptr <= '0;
      eend <= '0;
    end else if (erasing) begin
      eptr <= eptr + 1'b1;
      if (eptr == eend) erasing <= 1'b0;
    end else if (fl.op == UFSP_FOP_PAGE) begin
      erasing <= 1'b1;
      eptr <= fl.addr & ~AW'(PAGE_BYTES - 1);
      eend <= fl.addr | AW'(PAGE_BYTES - 1);
    end else if (fl.op == UFSP_FOP_MASS) begin
      erasing <= 1'b1;
      eptr <= '0;
      eend <= AW'(DEPTH - 1);
    end
  end

  // array access; programming only clears bits
  always_ff @(posedge clk_in) begin
    if (erasing) begin
      mem[eptr] <= 8'hff;
    end else if (fl.op == UFSP_FOP_WRITE) begin
      mem[fl.addr] <= mem[fl.addr] & fl.wdata;
    end
    if (fl.op == UFSP_FOP_READ) fl.rdata <= mem[fl.addr];
  end

  assign fl.busy = erasing || fl.op == UFSP_FOP_PAGE || fl.op == UFSP_FOP_MASS;
endmodule : ufsp_flash

// [rtl/ufsp_key_gate.sv]
`timescale 1ns/1ps
module ufsp_key_gate import ufsp_pkg::*; (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic key_write_in,
  input wire logic [7:0] key_value_in,
  input wire logic call_in,
  output logic key_ok_out
);
  logic [3:0] life;

  // key armed for a short window, spent by any call
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      life <= '0;
    end else if (key_write_in) begin
      life <= (key_value_in == KEY_VALUE) ? 4'(KEY_WINDOW_CYC) : 4'h0;
    end else if (call_in) begin
      life <= '0;
    end else if (life != 4'h0) begin
      life <= life - 4'h1;
    end
  end

  assign key_ok_out = life != 4'h0;
endmodule : ufsp_key_gate

// [rtl/ufsp_top.sv]
// Decided for this implementation: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module ufsp_top import ufsp_pkg::*; #(
  parameter int FLASH_DEPTH = 8192,
  parameter int PAGE_BYTES = 64,
  parameter int PROG_UNIT_CYCLES = 16
) (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic [11:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [11:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  output logic [7:0] ram_addr_out,
  output logic [7:0] ram_wdata_out,
  output logic ram_we_out,
  input wire logic [7:0] ram_rdata_in,
  input wire logic isp_exit_in,
  output logic isp_mode_out,
  output logic device_reset_out,
  output logic busy_out
);
  localparam int AW = $clog2(FLASH_DEPTH);

  typedef enum logic [9:0] {
    S_IDLE = 10'h001,
    S_ERASE = 10'h002,
    S_PROG = 10'h004,
    S_RD1 = 10'h008,
    S_RD2 = 10'h010,
    S_BW_RD = 10'h020,
    S_BW_WAIT = 10'h040,
    S_BW_DATA = 10'h080,
    S_ISP = 10'h100,
    S_RESET = 10'h200
  } ufsp_state_t;

  ufsp_state_t state;
  logic [11:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic wr_do;
  logic [7:0] flash_address_low;
  logic [7:0] flash_address_high;
  logic [7:0] read_result;
  logic [7:0] write_source;
  logic [7:0] write_timing;
  logic [7:0] call_key;
  logic [7:0] block_count;
  logic rejected;
  logic key_wr;
  logic call_wr;
  logic key_ok;
  logic call_go;
  logic [7:0] code;
  logic [7:0] acc;
  logic [AW-1:0] waddr;
  logic [7:0] xptr;
  logic [7:0] cnt;
  logic blk;
  logic mass;
  logic [15:0] tcnt;
  logic [15:0] tload;

  ufsp_flash_if #(.AW(AW)) fl ();

  ufsp_flash #(.DEPTH(FLASH_DEPTH), .PAGE_BYTES(PAGE_BYTES), .AW(AW)) u_flash (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .fl(fl.mem)
  );

  ufsp_key_gate u_key (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .key_write_in(key_wr),
    .key_value_in(wdata_q[7:0]),
    .call_in(call_wr),
    .key_ok_out(key_ok)
  );

  // true when a byte address selects a register index
  function automatic logic hit(input logic [11:0] a, input logic [9:0] idx);
    return a == {idx, 2'b00};
  endfunction : hit

  // write channel: address and data taken in either order
  assign wr_do = !s_axi_awready_out && !s_axi_wready_out && !s_axi_bvalid_out;

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      s_axi_awready_out <= 1'b1;
      s_axi_wready_out <= 1'b1;
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out <= RESP_OKAY;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
    end else begin
      if (s_axi_awvalid_in && s_axi_awready_out) begin
        awaddr_q <= s_axi_awaddr_in;
        s_axi_awready_out <= 1'b0;
      end
      if (s_axi_wvalid_in && s_axi_wready_out) begin
        wdata_q <= s_axi_wdata_in;
        wstrb_q <= s_axi_wstrb_in;
        s_axi_wready_out <= 1'b0;
      end
      if (wr_do) begin
        s_axi_bvalid_out <= 1'b1;
        if (hit(awaddr_q, IDX_ADDR_LOW) || hit(awaddr_q, IDX_ADDR_HIGH) || hit(awaddr_q, IDX_READ_RESULT)
            || hit(awaddr_q, IDX_WRITE_SOURCE) || hit(awaddr_q, IDX_WRITE_TIMING) || hit(awaddr_q, IDX_CALL_KEY)
            || hit(awaddr_q, IDX_BLOCK_COUNT) || hit(awaddr_q, IDX_CALL) || hit(awaddr_q, IDX_STATUS)) begin
          s_axi_bresp_out <= RESP_OKAY;
        end else begin
          s_axi_bresp_out <= RESP_SLVERR;
        end
      end else if (s_axi_bvalid_out && s_axi_bready_in) begin
        s_axi_bvalid_out <= 1'b0;
        s_axi_awready_out <= 1'b1;
        s_axi_wready_out <= 1'b1;
      end
    end
  end

  // read channel: data one cycle after the address is taken
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      s_axi_arready_out <= 1'b1;
      s_axi_rvalid_out <= 1'b0;
      s_axi_rdata_out <= '0;
      s_axi_rresp_out <= RESP_OKAY;
    end else if (s_axi_arvalid_in && s_axi_arready_out) begin
      s_axi_arready_out <= 1'b0;
      s_axi_rvalid_out <= 1'b1;
      s_axi_rresp_out <= RESP_OKAY;
      if (hit(s_axi_araddr_in, IDX_ADDR_LOW)) begin
        s_axi_rdata_out <= {24'h0, flash_address_low};
      end else if (hit(s_axi_araddr_in, IDX_ADDR_HIGH)) begin
        s_axi_rdata_out <= {24'h0, flash_address_high};
      end else if (hit(s_axi_araddr_in, IDX_READ_RESULT)) begin
        s_axi_rdata_out <= {24'h0, read_result};
      end else if (hit(s_axi_araddr_in, IDX_WRITE_SOURCE)) begin
        s_axi_rdata_out <= {24'h0, write_source};
      end else if (hit(s_axi_araddr_in, IDX_WRITE_TIMING)) begin
        s_axi_rdata_out <= {24'h0, write_timing};
      end else if (hit(s_axi_araddr_in, IDX_CALL_KEY)) begin
        s_axi_rdata_out <= {24'h0, call_key};
      end else if (hit(s_axi_araddr_in, IDX_BLOCK_COUNT)) begin
        s_axi_rdata_out <= {24'h0, block_count};
      end else if (hit(s_axi_araddr_in, IDX_CALL)) begin
        s_axi_rdata_out <= {8'h0, xptr, acc, code};
      end else if (hit(s_axi_araddr_in, IDX_STATUS)) begin
        s_axi_rdata_out <= {28'h0, key_ok, rejected, isp_mode_out, busy_out};
      end else begin
        s_axi_rdata_out <= '0;
        s_axi_rresp_out <= RESP_SLVERR;
      end
    end else if (s_axi_rvalid_out && s_axi_rready_in) begin
      s_axi_rvalid_out <= 1'b0;
      s_axi_arready_out <= 1'b1;
    end
  end

  // register write strobes
  assign key_wr = wr_do && wstrb_q[0] && hit(awaddr_q, IDX_CALL_KEY);
  assign call_wr = wr_do && wstrb_q[0] && hit(awaddr_q, IDX_CALL);
  assign call_go = call_wr && key_ok && state == S_IDLE;

  // software parameter registers; service result wins on read_result
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      flash_address_low <= RST_BYTE;
      flash_address_high <= RST_BYTE;
      write_source <= RST_BYTE;
      write_timing <= RST_BYTE;
      call_key <= RST_BYTE;
      block_count <= RST_BYTE;
    end else if (wr_do && wstrb_q[0]) begin
      if (hit(awaddr_q, IDX_ADDR_LOW)) begin
        flash_address_low <= wdata_q[7:0];
      end else if (hit(awaddr_q, IDX_ADDR_HIGH)) begin
        flash_address_high <= wdata_q[7:0];
      end else if (hit(awaddr_q, IDX_WRITE_SOURCE)) begin
        write_source <= wdata_q[7:0];
      end else if (hit(awaddr_q, IDX_WRITE_TIMING)) begin
        write_timing <= wdata_q[7:0];
      end else if (hit(awaddr_q, IDX_CALL_KEY)) begin
        call_key <= wdata_q[7:0];
      end else if (hit(awaddr_q, IDX_BLOCK_COUNT)) begin
        block_count <= wdata_q[7:0];
      end
    end
  end

  // call code and acc captured on every call write; x only on an accepted call
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      code <= RST_BYTE;
      acc <= RST_BYTE;
    end else if (call_wr) begin
      code <= wdata_q[CALL_CODE_LSB +: 8];
      acc <= wdata_q[CALL_ACC_LSB +: 8];
    end
  end

  // sticky rejection flag, write one to clear, a new rejection wins
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      rejected <= 1'b0;
    end else if (call_wr && !call_go) begin
      rejected <= 1'b1;
    end else if (wr_do && wstrb_q[0] && hit(awaddr_q, IDX_STATUS) && wdata_q[ST_REJECT]) begin
      rejected <= 1'b0;
    end
  end

  // erase and program duration from write_timing
  assign tload = 16'(write_timing * PROG_UNIT_CYCLES);

  // service sequencer
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      state <= S_IDLE;
      fl.op <= UFSP_FOP_NONE;
      fl.addr <= '0;
      fl.wdata <= '0;
      waddr <= '0;
      xptr <= '0;
      cnt <= '0;
      blk <= 1'b0;
      mass <= 1'b0;
      tcnt <= '0;
      read_result <= RST_BYTE;
      ram_addr_out <= '0;
      ram_wdata_out <= '0;
      ram_we_out <= 1'b0;
      isp_mode_out <= 1'b0;
      device_reset_out <= 1'b0;
    end else begin
      fl.op <= UFSP_FOP_NONE;
      ram_we_out <= 1'b0;
      device_reset_out <= 1'b0;
      if (tcnt != 16'h0) tcnt <= tcnt - 16'h1;
      if (wr_do && wstrb_q[0] && hit(awaddr_q, IDX_READ_RESULT)) read_result <= wdata_q[7:0];
      case (state)
        S_IDLE: begin
          if (call_go) begin
            waddr <= AW'({flash_address_high, flash_address_low});
            fl.addr <= AW'({flash_address_high, flash_address_low});
            xptr <= wdata_q[CALL_X_LSB +: 8];
            cnt <= block_count;
            blk <= 1'b0;
            mass <= 1'b0;
            tcnt <= tload;
            // entry code selects the service
            case (wdata_q[CALL_CODE_LSB +: 8])
              EP_PAGE_ERASE: begin
                fl.op <= UFSP_FOP_PAGE;
                state <= S_ERASE;
              end
              EP_MASS_ERASE: begin
                if (wdata_q[CALL_ACC_LSB +: 8] == MASS_CONFIRM) begin
                  fl.op <= UFSP_FOP_MASS;
                  mass <= 1'b1;
                  state <= S_ERASE;
                end
              end
              EP_READ_BYTE: begin
                fl.op <= UFSP_FOP_READ;
                state <= S_RD1;
              end
              EP_WRITE_BYTE: begin
                fl.op <= UFSP_FOP_WRITE;
                fl.wdata <= write_source;
                state <= S_PROG;
              end
              EP_BLOCK_READ: begin
                blk <= 1'b1;
                if (block_count != 8'h0) begin
                  fl.op <= UFSP_FOP_READ;
                  state <= S_RD1;
                end
              end
              EP_BLOCK_WRITE: begin
                blk <= 1'b1;
                if (block_count != 8'h0 && block_count <= BLKW_MAX) state <= S_BW_RD;
              end
              EP_EXIT: state <= S_RESET;
              EP_ISP_START: state <= S_ISP;
              default: state <= S_IDLE;
            endcase
          end
        end
        S_ERASE: begin
          if (!fl.busy && tcnt == 16'h0) state <= mass ? S_ISP : S_IDLE;
        end
        S_RD1: state <= S_RD2;
        S_RD2: begin
          if (blk) begin
            ram_we_out <= 1'b1;
            ram_addr_out <= xptr;
            ram_wdata_out <= fl.rdata;
            xptr <= xptr + 8'h1;
            waddr <= waddr + 1'b1;
            fl.addr <= waddr + 1'b1;
            cnt <= cnt - 8'h1;
            if (cnt == 8'h1) begin
              state <= S_IDLE;
            end else begin
              fl.op <= UFSP_FOP_READ;
              state <= S_RD1;
            end
          end else begin
            read_result <= fl.rdata;
            state <= S_IDLE;
          end
        end
        S_BW_RD: begin
          ram_addr_out <= xptr;
          state <= S_BW_WAIT;
        end
        S_BW_WAIT: state <= S_BW_DATA;
        S_BW_DATA: begin
          fl.op <= UFSP_FOP_WRITE;
          fl.addr <= waddr;
          fl.wdata <= ram_rdata_in;
          tcnt <= tload;
          state <= S_PROG;
        end
        S_PROG: begin
          if (tcnt == 16'h0) begin
            if (blk && cnt != 8'h1) begin
              xptr <= xptr + 8'h1;
              waddr <= waddr + 1'b1;
              cnt <= cnt - 8'h1;
              state <= S_BW_RD;
            end else begin
              state <= S_IDLE;
            end
          end
        end
        S_ISP: begin
          isp_mode_out <= 1'b1;
          if (isp_exit_in) state <= S_RESET;
        end
        S_RESET: begin
          isp_mode_out <= 1'b0;
          device_reset_out <= 1'b1;
          state <= S_IDLE;
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  // busy flag lags the state by one clock
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      busy_out <= 1'b0;
    end else begin
      busy_out <= state != S_IDLE;
    end
  end
endmodule : ufsp_top

// [sim/ufsp_checker.sv]
`timescale 1ns/1ps
module ufsp_checker import ufsp_pkg::*; (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic [11:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  input wire logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic s_axi_wvalid_in,
  input wire logic s_axi_wready_out,
  input wire logic s_axi_bvalid_out,
  input wire logic [31:0] s_axi_rdata_out,
  input wire logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  input wire logic ram_we_out,
  input wire logic isp_exit_in,
  input wire logic isp_mode_out,
  input wire logic device_reset_out,
  input wire logic busy_out
);
  logic [11:0] aw_q;
  logic [23:0] wd_q;
  logic bv_q;
  logic [3:0] age;
  // register write lands in the first cycle of bvalid
  wire commit = s_axi_bvalid_out && !bv_q;
  wire call_w = commit && aw_q[11:2] == IDX_CALL;
  wire armed = call_w && age <= 4'h4 && !busy_out && !isp_mode_out;
  wire dead = call_w && age >= 4'h8 && !busy_out;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  // capture of the write request
  always_ff @(posedge clk_in) begin
    if (s_axi_awvalid_in && s_axi_awready_out) aw_q <= s_axi_awaddr_in;
    if (s_axi_wvalid_in && s_axi_wready_out) wd_q <= s_axi_wdata_in[23:0];
    bv_q <= s_axi_bvalid_out;
  end
  // clocks since the key value was stored, margin kept on both sides
  always_ff @(posedge clk_in) begin
    if (!reset_n_in || call_w) begin
      age <= 4'hf;
    end else if (commit && aw_q[11:2] == IDX_CALL_KEY) begin
      age <= (wd_q[7:0] == KEY_VALUE) ? 4'h0 : 4'hf;
    end else if (age != 4'hf) begin
      age <= age + 4'h1;
    end
  end
  sequence exit_req_s;
    isp_mode_out && isp_exit_in;
  endsequence
  sequence call_s(logic [7:0] code);
    armed && wd_q[7:0] == code;
  endsequence
  key_refuse_a: assert property (dead |=> (!busy_out && !ram_we_out) [*3])
    else $error("unkeyed call started work");
  exit_reset_a: assert property (call_s(EP_EXIT) |-> ##[1:3] device_reset_out)
    else $error("exit call gave no reset");
  isp_start_a: assert property (call_s(EP_ISP_START) |-> ##[1:4] isp_mode_out)
    else $error("isp start call gave no isp mode");
  mass_guard_a: assert property (call_s(EP_MASS_ERASE) ##0 wd_q[15:8] != MASS_CONFIRM |=> !isp_mode_out [*6])
    else $error("mass erase ran without confirmation");
  // mode flag trails the exit by one clock, so a just-seen exit is excluded
  isp_hold_a: assert property (isp_mode_out && !isp_exit_in && !$past(isp_exit_in) |=> isp_mode_out)
    else $error("isp mode left without exit");
  isp_leave_a: assert property (exit_req_s |-> ##[1:4] device_reset_out)
    else $error("isp exit gave no reset");
  reset_pulse_a: assert property (device_reset_out |=> !device_reset_out)
    else $error("reset request longer than one cycle");
  ram_pulse_a: assert property (ram_we_out |=> !ram_we_out)
    else $error("ram write strobe too long");
  ram_busy_a: assert property (ram_we_out |-> busy_out)
    else $error("ram write while idle");
  rdata_hold_a: assert property (s_axi_rvalid_out && !s_axi_rready_in |=> s_axi_rvalid_out && $stable(s_axi_rdata_out))
    else $error("read data dropped early");
  resp_wait_a: assert property (s_axi_bvalid_out |-> !s_axi_awready_out && !s_axi_wready_out)
    else $error("write ready during response");
endmodule : ufsp_checker
bind ufsp_top ufsp_checker u_checker (.clk_in, .reset_n_in, .s_axi_awaddr_in, .s_axi_awvalid_in, .s_axi_awready_out,
  .s_axi_wdata_in, .s_axi_wvalid_in, .s_axi_wready_out, .s_axi_bvalid_out, .s_axi_rdata_out, .s_axi_rvalid_out,
  .s_axi_rready_in, .ram_we_out, .isp_exit_in, .isp_mode_out, .device_reset_out, .busy_out);

// [sim/ufsp_top_tb.sv]
`timescale 1ns/1ps
module ufsp_top_tb;
  import ufsp_pkg::*;
  logic clk_in = 1'h0;
  logic reset_n_in = 1'h0;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic awvalid = 1'h0, wvalid = 1'h0, arvalid = 1'h0, isp_exit = 1'h0;
  logic [31:0] wdata = 32'h00000000, rdata, st;
  logic awready, wready, bvalid, arready, rvalid, ram_we, isp_mode, dev_rst, busy;
  logic [1:0] bresp, rresp, br;
  logic [7:0] ram_addr, ram_wdata, d;
  logic [7:0] ram_rdata = 8'h00;
  logic rready = 1'h1;
  logic [7:0] ram [0:255];
  logic [34:0] n;
  logic [34:0] rd_q[$];
  logic [15:0] we_q[$];
  logic [9:0] regs [7] = '{IDX_ADDR_LOW, IDX_ADDR_HIGH, IDX_READ_RESULT, IDX_WRITE_SOURCE, IDX_WRITE_TIMING,
    IDX_CALL_KEY, IDX_BLOCK_COUNT};
  int failures = 0, tests_run = 0, seed = 44, resets = 0;
  always #4 clk_in = ~clk_in;
  ufsp_top #(.FLASH_DEPTH(256)) DUT (.clk_in(clk_in), .reset_n_in(reset_n_in), .s_axi_awaddr_in(awaddr),
    .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready), .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hf),
    .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
    .s_axi_bready_in(1'h1), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
    .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready),
    .ram_addr_out(ram_addr), .ram_wdata_out(ram_wdata), .ram_we_out(ram_we), .ram_rdata_in(ram_rdata),
    .isp_exit_in(isp_exit), .isp_mode_out(isp_mode), .device_reset_out(dev_rst), .busy_out(busy));
  // ram data ready one edge after the address moves
  always @(posedge clk_in) begin
    ram_rdata <= ram[ram_addr];
  end
  // output watcher, oldest note first
  always @(posedge clk_in) begin
    if (rvalid && rready) begin
      n = rd_q.pop_front();
      if (n[34]) check("rdata", {1'h0, rresp, rdata}, {1'h0, n[33:0]});
    end
    if (ram_we) check("ram", 35'({ram_addr, ram_wdata}), we_q.size() ? 35'(we_q.pop_front()) : 35'h7ffffffff);
    if (dev_rst) resets++;
  end
  task automatic check(input string name, input logic [34:0] seen, input logic [34:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic wr(input logic [9:0] idx, input logic [31:0] val);
    awaddr <= {idx, 2'h0};
    wdata <= val;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    do begin
      @(posedge clk_in);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
    end while (!bvalid);
    br = bresp;
  endtask : wr
  task automatic rd(input logic [9:0] idx, input logic chk, input logic [33:0] exp, output logic [31:0] data);
    rd_q.push_back({chk, exp});
    araddr <= {idx, 2'h0};
    arvalid <= 1'h1;
    rready <= 1'($random(seed)); // random stall of the data phase
    do @(posedge clk_in); while (!arready);
    arvalid <= 1'h0;
    do begin
      @(posedge clk_in);
      if (!rready) rready <= 1'h1;
    end while (!(rvalid && rready));
    data = rdata;
  endtask : rd
  task automatic faddr(input logic [15:0] a);
    wr(IDX_ADDR_LOW, {24'h000000, a[7:0]});
    wr(IDX_ADDR_HIGH, {24'h000000, a[15:8]});
  endtask : faddr
  // keyed call, then poll busy until clear
  task automatic svc(input logic [7:0] code, input logic [7:0] acc, input logic [7:0] x, input logic done);
    logic [31:0] s;
    wr(IDX_CALL_KEY, {24'h000000, KEY_VALUE});
    wr(IDX_CALL, {8'h00, x, acc, code});
    s = 32'h00000001;
    for (int i = 0; done && i < 400 && (i < 2 || s[0]); i++) rd(IDX_STATUS, 1'h0, 34'h0, s);
    if (done) check("idle", 35'(s[0]), 35'h0);
  endtask : svc
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : conclude
  initial begin
    repeat (60000) @(posedge clk_in);
    failures++;
    conclude();
  end
  // main sequence
  initial begin
    for (int i = 0; i < 256; i++) ram[i] = $random(seed);
    repeat (8) @(posedge clk_in);
    reset_n_in <= 1'h1;
    @(posedge clk_in);
    foreach (regs[i]) rd(regs[i], 1'h1, {RESP_OKAY, 32'h0}, st);
    rd(10'h3ff, 1'h1, {RESP_SLVERR, 32'h0}, st);
    wr(10'h3ff, 32'h00000000);
    check("bresp", 35'(br), 35'(RESP_SLVERR));
    wr(IDX_WRITE_TIMING, 32'h00000000);
    check("bresp_ok", 35'(br), 35'(RESP_OKAY));
    faddr(16'h0100);
    svc(EP_PAGE_ERASE, 8'h00, 8'h00, 1'h1);
    svc(EP_READ_BYTE, 8'h00, 8'h00, 1'h1);
    rd(IDX_READ_RESULT, 1'h1, {RESP_OKAY, 32'hff}, st);
    d = $random(seed);
    faddr(16'h0105);
    wr(IDX_WRITE_SOURCE, {24'h000000, d});
    svc(EP_WRITE_BYTE, 8'h00, 8'h00, 1'h1);
    svc(EP_READ_BYTE, 8'h00, 8'h00, 1'h1);
    rd(IDX_READ_RESULT, 1'h1, {RESP_OKAY, 24'h0, d}, st);
    faddr(16'h0108);
    wr(IDX_BLOCK_COUNT, 32'h00000003);
    svc(EP_BLOCK_WRITE, 8'h00, 8'h20, 1'h1);
    faddr(16'h0110);
    wr(IDX_BLOCK_COUNT, 32'h00000011);
    svc(EP_BLOCK_WRITE, 8'h00, 8'h20, 1'h1);
    for (int i = 0; i < 12; i++) we_q.push_back({8'h50 + i[7:0], i == 0 ? d : (i > 2 && i < 6) ? ram[8'h1d + i[7:0]] : 8'hff});
    faddr(16'h0105);
    wr(IDX_BLOCK_COUNT, 32'h0000000c);
    svc(EP_BLOCK_READ, 8'h00, 8'h50, 1'h1);
    wr(IDX_BLOCK_COUNT, 32'h00000000);
    svc(EP_BLOCK_READ, 8'h00, 8'h60, 1'h1);
    check("pending", 35'(we_q.size()), 35'h0);
    // calls with no key and a wrong key do nothing
    faddr(16'h0106);
    wr(IDX_WRITE_SOURCE, 32'h00000000);
    wr(IDX_CALL, {24'h0000, EP_WRITE_BYTE});
    wr(IDX_CALL_KEY, 32'h00000097);
    wr(IDX_CALL, {24'h0000, EP_WRITE_BYTE});
    repeat (4) @(posedge clk_in);
    rd(IDX_STATUS, 1'h1, {RESP_OKAY, 32'h4}, st);
    wr(IDX_STATUS, 32'h00000004);
    svc(EP_READ_BYTE, 8'h00, 8'h00, 1'h1);
    rd(IDX_READ_RESULT, 1'h1, {RESP_OKAY, 32'hff}, st);
    svc(EP_MASS_ERASE, 8'h54, 8'h00, 1'h1);
    rd(IDX_CALL, 1'h1, {RESP_OKAY, 32'h0000541a}, st);
    faddr(16'h0105);
    svc(EP_READ_BYTE, 8'h00, 8'h00, 1'h1);
    rd(IDX_READ_RESULT, 1'h1, {RESP_OKAY, 24'h0, d}, st);
    svc(EP_EXIT, 8'h00, 8'h00, 1'h1);
    svc(EP_ISP_START, 8'h00, 8'h00, 1'h0);
    repeat (4) @(posedge clk_in);
    rd(IDX_STATUS, 1'h0, 34'h0, st);
    check("isp", 35'(st[1]), 35'h1);
    isp_exit <= 1'h1;
    @(posedge clk_in);
    isp_exit <= 1'h0;
    repeat (6) @(posedge clk_in);
    check("isp_off", 35'(isp_mode), 35'h0);
    svc(EP_MASS_ERASE, MASS_CONFIRM, 8'h00, 1'h0);
    for (int i = 0; i < 2000 && isp_mode !== 1'h1; i++) @(posedge clk_in);
    check("mass_isp", 35'(isp_mode), 35'h1);
    isp_exit <= 1'h1;
    @(posedge clk_in);
    isp_exit <= 1'h0;
    repeat (6) @(posedge clk_in);
    check("resets", 35'(resets), 35'h3);
    conclude();
  end
endmodule : ufsp_top_tb
